/* cdp_pkg.sv */
package cdp_pkg;
    // register byte addresses on the peripheral bus
    localparam logic [31:0] RESP0_ADDR = 32'he008c014;
    localparam logic [31:0] RESP1_ADDR = 32'he008c018;
    localparam logic [31:0] RESP2_ADDR = 32'he008c01c;
    localparam logic [31:0] RESP3_ADDR = 32'he008c020;
    localparam logic [31:0] TMR_ADDR = 32'he008c024;
    localparam logic [31:0] LEN_ADDR = 32'he008c028;
    localparam logic [31:0] CTRL_ADDR = 32'he008c02c;
    localparam logic [31:0] CNT_ADDR = 32'he008c030;
    localparam logic [31:0] FLAG_ADDR = 32'he008c0f0;
    localparam logic [31:0] FLAG_CLR_ADDR = 32'he008c0f4;
    // reset values
    localparam logic [31:0] TMR_RST = 32'h0000_0000;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // flag register bit positions
    localparam int TOUT_BIT = 3;
    localparam int DEND_BIT = 8;
    localparam int TXACT_BIT = 12;
    localparam int RXACT_BIT = 13;
    // response and data block framing
    localparam int SHORT_BITS = 32;
    localparam int LONG_BITS = 127;
    localparam int BLK_MAX = 11;
    localparam int BLK_LEN_W = 12;
    // bus answers
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_DECERR = 2'h3;

    // data-path control word, bit 0 upward: enable, direction, stream, dma, block size
    typedef struct packed {
        logic [3:0] blk_exp;
        logic dma;
        logic stream;
        logic dir;
        logic en;
    } cdp_ctrl_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_S = 3'b001,
        ST_SEND = 3'b010,
        ST_BUSY = 3'b011,
        ST_WAIT_R = 3'b100,
        ST_RECV = 3'b101
    } cdp_state_type;
endpackage

/* cdp_sync.sv */
`timescale 1ns/1ps
module cdp_sync
    import cdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level,
    output logic rise
);
    logic s1;
    logic s2;
    logic s3;
    wire agree = (s2 == s3);

    // three stages; the level moves only once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (agree)
                level <= s3;
        end
    end

    assign rise = agree && s3 && !level;
endmodule

/* cdp_resp_capture.sv */
`timescale 1ns/1ps
module cdp_resp_capture
    import cdp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic bit_in,
    input wire logic bit_valid,
    input wire logic done,
    input wire logic long_sel,
    output logic [3:0][31:0] words
);
    logic [LONG_BITS-1:0] shift;
    wire [127:0] long_img = {shift, 1'b0};

    // earliest bit ends at the top because every new bit enters at the bottom
    always_ff @(posedge clk)
    begin
        if (rst || start)
            shift <= '0;
        else if (bit_valid)
            shift <= {shift[LONG_BITS-2:0], bit_in};
    end

    // word 0 carries the most significant part; short status touches word 0 only
    always_ff @(posedge clk)
    begin
        if (rst)
            words <= '0;
        else if (done && long_sel)
            words <= {long_img[31:0], long_img[63:32], long_img[95:64], long_img[127:96]};
        else if (done)
            words[0] <= shift[SHORT_BITS-1:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_short_only;
        done && !long_sel |=> $stable(words[3:1]) && words[0] == $past(shift[SHORT_BITS-1:0]);
    endproperty
    a_short_only: assert property (p_short_only) else $error("short response touched upper words");

    property p_lsb_zero;
        done && long_sel |=> words[3][0] == 1'b0 && words[0] == $past(shift[LONG_BITS-1:LONG_BITS-32]);
    endproperty
    a_lsb_zero: assert property (p_lsb_zero) else $error("long response misplaced");
endmodule

/* cdp_data_path.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module cdp_data_path
    import cdp_pkg::*;
#(
    parameter int LEN_W = 16,
    parameter int TMR_W = 32
)
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CARD_BUS_CLOCK,
    input wire logic CARD_BUSY,
    input wire logic RESP_START,
    input wire logic RESP_BIT,
    input wire logic RESP_BIT_VALID,
    input wire logic RESP_DONE,
    input wire logic LONG_RESPONSE_SELECT,
    input wire logic TX_READY,
    input wire logic RX_START_BIT,
    input wire logic BYTE_MOVED,
    output logic DATA_DIR,
    output logic STREAM_MODE,
    output logic [BLK_LEN_W-1:0] BLOCK_LEN,
    output logic DMA_REQUEST,
    output logic TX_ACTIVE,
    output logic RX_ACTIVE,
    output logic DATA_END_FLAG,
    output logic DATA_TIMEOUT_FLAG
);
    if (LEN_W < 1 || LEN_W > 32 || TMR_W < 1 || TMR_W > 32)
    begin : g_width_check
        $error("cdp_data_path: LEN_W and TMR_W must be 1 to 32");
    end

    // byte lanes a write may touch, the rest keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    endfunction

    // reserved exponents give no block length rather than a wrapped one
    function automatic logic [BLK_LEN_W-1:0] blk_len(input logic [3:0] e);
        blk_len = (e <= 4'(BLK_MAX)) ? (12'h001 << e) : '0;
    endfunction

    cdp_state_type state;
    cdp_state_type next_state;
    cdp_ctrl_type ctrl;
    logic [TMR_W-1:0] period;
    logic [LEN_W-1:0] length;
    logic [LEN_W-1:0] remain;
    logic [TMR_W-1:0] timer;
    logic tout_flag;
    logic dend_flag;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [3:0][31:0] resp_words;
    logic busy_lvl;
    logic card_edge;

    // card bus clock and busy line come from outside, sampled here
    cdp_sync u_clk_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .pin(CARD_BUS_CLOCK),
        .level(),
        .rise(card_edge)
    );

    cdp_sync u_busy_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .pin(CARD_BUSY),
        .level(busy_lvl),
        .rise()
    );

    // the command path frames 136 bits; only the status part arrives here
    cdp_resp_capture u_resp (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .start(RESP_START),
        .bit_in(RESP_BIT),
        .bit_valid(RESP_BIT_VALID),
        .done(RESP_DONE),
        .long_sel(LONG_RESPONSE_SELECT),
        .words(resp_words)
    );

    // write side: address and data are taken together, one write at a time
    wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
    wire [31:0] wa = S_AXI_AWADDR;
    wire wr_tmr = wr_go && wa == TMR_ADDR;
    wire wr_len = wr_go && wa == LEN_ADDR;
    wire wr_ctrl = wr_go && wa == CTRL_ADDR;
    wire wr_clr = wr_go && wa == FLAG_CLR_ADDR;
    wire wr_ro = wr_go && (wa == CNT_ADDR || wa == FLAG_ADDR || wa == RESP0_ADDR || wa == RESP1_ADDR
                           || wa == RESP2_ADDR || wa == RESP3_ADDR);
    wire wr_hit = wr_tmr || wr_len || wr_ctrl || wr_clr || wr_ro;
    wire [31:0] ctrl_merged = merge({24'h000000, ctrl}, S_AXI_WDATA, S_AXI_WSTRB);
    wire [31:0] clr_bits = S_AXI_WDATA & merge(32'h0000_0000, 32'hffff_ffff, S_AXI_WSTRB);
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;

    // read side: one read at a time, data one cycle after the address
    wire rd_go = S_AXI_ARVALID && !rvalid;
    assign S_AXI_ARREADY = rd_go;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;

    // data-path sequencing terms
    wire start = wr_ctrl && ctrl_merged[0] && state == ST_IDLE;
    wire start_dir = ctrl_merged[1];
    wire active = state != ST_IDLE;
    wire moving = state == ST_SEND || state == ST_RECV;
    wire timing = state == ST_WAIT_R || state == ST_BUSY;
    wire remain_zero = remain == '0;
    wire timer_zero = timer == '0;
    wire tout_evt = timing && timer_zero;
    wire dend_evt = active && remain_zero && !tout_evt;
    wire timer_load = (next_state == ST_WAIT_R || next_state == ST_BUSY) && next_state != state;

    // address decode for reads; reserved bits above each field read as zero
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (S_AXI_ARADDR == RESP0_ADDR)
            rd_mux = resp_words[0];
        else if (S_AXI_ARADDR == RESP1_ADDR)
            rd_mux = resp_words[1];
        else if (S_AXI_ARADDR == RESP2_ADDR)
            rd_mux = resp_words[2];
        else if (S_AXI_ARADDR == RESP3_ADDR)
            rd_mux = {resp_words[3][31:1], 1'b0};
        else if (S_AXI_ARADDR == TMR_ADDR)
            rd_mux = 32'(period);
        else if (S_AXI_ARADDR == LEN_ADDR)
            rd_mux = 32'(length);
        else if (S_AXI_ARADDR == CTRL_ADDR)
            rd_mux = {24'h000000, ctrl};
        else if (S_AXI_ARADDR == CNT_ADDR)
            rd_mux = 32'(remain);
        else if (S_AXI_ARADDR == FLAG_ADDR)
        begin
            rd_mux[TOUT_BIT] = tout_flag;
            rd_mux[DEND_BIT] = dend_flag;
            rd_mux[TXACT_BIT] = TX_ACTIVE;
            rd_mux[RXACT_BIT] = RX_ACTIVE;
        end
        else
            rd_hit = 1'b0;
    end

    // write answer, decode error for holes in the map
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
        end
        else if (wr_go)
        begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? AXI_OKAY : AXI_DECERR;
        end
        else if (S_AXI_BREADY)
            bvalid <= 1'b0;
    end

    // read answer is registered so the data never glitch at the port
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= AXI_OKAY;
        end
        else if (rd_go)
        begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? AXI_OKAY : AXI_DECERR;
        end
        else if (S_AXI_RREADY)
            rvalid <= 1'b0;
    end

    // software-written setup; the remaining count has no write path
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            period <= TMR_W'(TMR_RST);
            length <= '0;
            ctrl <= cdp_ctrl_type'(CTRL_RST);
        end
        else
        begin
            if (wr_tmr)
                period <= TMR_W'(merge(32'(period), S_AXI_WDATA, S_AXI_WSTRB));
            if (wr_len)
                length <= LEN_W'(merge(32'(length), S_AXI_WDATA, S_AXI_WSTRB));
            if (wr_ctrl)
                ctrl <= cdp_ctrl_type'(ctrl_merged[7:0]);
        end
    end

    // data-path state machine; a timeout wins over a count that hits zero together
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (start)
                    next_state = start_dir ? ST_WAIT_R : ST_WAIT_S;
            ST_WAIT_S:
                if (remain_zero)
                    next_state = ST_IDLE;
                else if (TX_READY)
                    next_state = ST_SEND;
            ST_SEND:
                if (remain_zero)
                    next_state = ST_IDLE;
                else if (busy_lvl)
                    next_state = ST_BUSY;
            ST_BUSY:
                if (timer_zero)
                    next_state = ST_IDLE;
                else if (!busy_lvl)
                    next_state = ST_SEND;
            ST_WAIT_R:
                if (timer_zero || remain_zero)
                    next_state = ST_IDLE;
                else if (RX_START_BIT)
                    next_state = ST_RECV;
            ST_RECV:
                if (remain_zero)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // remaining count: loaded on the way out of idle, one less per byte moved
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            remain <= '0;
        else if (state == ST_IDLE && next_state != ST_IDLE)
            remain <= length;
        else if (moving && BYTE_MOVED && !remain_zero)
            remain <= remain - 1'b1;
    end

    // timeout counter ticks on rising card clock edges, so a stopped card clock freezes it
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            timer <= '0;
        else if (timer_load)
            timer <= period;
        else if (timing && card_edge && !timer_zero)
            timer <= timer - 1'b1;
    end

    // sticky flags; a new event in the clearing cycle keeps the flag set
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
        begin
            tout_flag <= 1'b0;
            dend_flag <= 1'b0;
        end
        else
        begin
            tout_flag <= tout_evt || (tout_flag && !(wr_clr && clr_bits[TOUT_BIT]));
            dend_flag <= dend_evt || (dend_flag && !(wr_clr && clr_bits[DEND_BIT]));
        end
    end

    // mode outputs held in flops so the serialiser sees steady values
    always_ff @(posedge CLK_SYS)
    begin
        if (SYS_RST)
            BLOCK_LEN <= '0;
        else
            BLOCK_LEN <= ctrl.stream ? '0 : blk_len(ctrl.blk_exp);
    end

    assign DATA_DIR = ctrl.dir;
    assign STREAM_MODE = ctrl.stream;
    assign DMA_REQUEST = ctrl.dma && moving;
    assign TX_ACTIVE = state == ST_WAIT_S || state == ST_SEND || state == ST_BUSY;
    assign RX_ACTIVE = state == ST_WAIT_R || state == ST_RECV;
    assign DATA_END_FLAG = dend_flag;
    assign DATA_TIMEOUT_FLAG = tout_flag;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    logic [31:0] past_araddr;
    always_ff @(posedge CLK_SYS)
    begin
        if (rd_go)
            past_araddr <= S_AXI_ARADDR;
    end

    property p_start_dir;
        state == ST_IDLE && wr_ctrl && ctrl_merged[0] |=> state == (ctrl.dir ? ST_WAIT_R : ST_WAIT_S);
    endproperty
    a_start_dir: assert property (p_start_dir) else $error("start did not reach the wait state");

    property p_load_remain;
        state == ST_IDLE ##1 state != ST_IDLE |-> remain == $past(length);
    endproperty
    a_load_remain: assert property (p_load_remain) else $error("remaining count not loaded");

    property p_count_down;
        moving && BYTE_MOVED && !remain_zero |=> remain == $past(remain) - 1'b1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("remaining count missed a byte");

    sequence s_last_byte;
        active && remain_zero && !tout_evt;
    endsequence
    sequence s_back_idle;
        state == ST_IDLE && dend_flag ##1 DATA_END_FLAG;
    endsequence
    property p_data_end;
        s_last_byte |=> s_back_idle;
    endproperty
    a_data_end: assert property (p_data_end) else $error("data end not reached");

    property p_timeout;
        timing && timer_zero |=> tout_flag && state == ST_IDLE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag missing");

    property p_timer_load;
        state == ST_IDLE && wr_ctrl && ctrl_merged[1:0] == 2'h3 |=> timer == $past(period);
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("timer not loaded on receive wait");

    property p_timer_hold;
        timing && !card_edge && !timer_load |=> timer == $past(timer);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("timer moved without card clock");

    property p_resp3_lsb;
        rvalid && past_araddr == RESP3_ADDR |-> S_AXI_RDATA[0] == 1'b0;
    endproperty
    a_resp3_lsb: assert property (p_resp3_lsb) else $error("response word 3 lsb not zero");

    property p_len_reserved;
        rvalid && past_araddr == LEN_ADDR |-> S_AXI_RDATA[31:LEN_W] == '0;
    endproperty
    a_len_reserved: assert property (p_len_reserved) else $error("length reserved bits set");

    property p_remain_ro;
        state == ST_IDLE && next_state == ST_IDLE && wr_go && wa == CNT_ADDR |=> $stable(remain);
    endproperty
    a_remain_ro: assert property (p_remain_ro) else $error("remaining count took a write");

    property p_blk_len;
        wr_ctrl && !ctrl_merged[2] ##1 1'b1 |=> BLOCK_LEN == blk_len($past(ctrl.blk_exp));
    endproperty
    a_blk_len: assert property (p_blk_len) else $error("block length wrong");
endmodule

/* cdp_card_model.sv */
`timescale 1ns/1ps
module cdp_card_model (
    input wire logic run,
    input wire logic busy_req,
    output logic card_clk,
    output wire logic card_busy
);
    // card clock toggles only inside a frame and parks low between frames
    initial
    begin
        card_clk = 1'b0;
        forever
        begin
            #80;
            card_clk = run ? ~card_clk : 1'b0;
        end
    end
    // busy trails the request, as a slow card would
    assign #100 card_busy = busy_req;
endmodule

/* card_data_path_regs_bench.sv */
`timescale 1ns/1ps
module card_data_path_regs_bench;
    import cdp_pkg::*;
    logic CLK_SYS, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_ARADDR, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic CARD_BUS_CLOCK, CARD_BUSY, RESP_START, RESP_BIT, RESP_BIT_VALID, RESP_DONE;
    logic LONG_RESPONSE_SELECT, TX_READY, RX_START_BIT, BYTE_MOVED, DATA_DIR, STREAM_MODE;
    logic DMA_REQUEST, TX_ACTIVE, RX_ACTIVE, DATA_END_FLAG, DATA_TIMEOUT_FLAG, run, busy_req;
    logic [BLK_LEN_W-1:0] BLOCK_LEN;
    int mismatches = 0;
    int checks = 0;
    cdp_data_path cdp_data_path_i (.*);
    cdp_card_model cdp_card_model_i (.run(run), .busy_req(busy_req), .card_clk(CARD_BUS_CLOCK),
        .card_busy(CARD_BUSY));
    // 50 MHz system clock
    initial
    begin
        CLK_SYS = 1'b0;
        forever
        begin
            #10;
            CLK_SYS = ~CLK_SYS;
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // bounded wait, sampled at the rising edge; running out ends the run
    task automatic wt(ref logic s, input int lim);
        int n;
        n = 0;
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end
        while (s !== 1'b1 && n < lim);
        if (s !== 1'b1)
        begin
            chk(32'h0, 32'h1, "wait expired");
            close_out();
        end
    endtask
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        wt(S_AXI_AWREADY, 20);
        S_AXI_AWVALID <= 1'b0;
        S_AXI_WVALID <= 1'b0;
        wt(S_AXI_BVALID, 20);
        chk(32'(S_AXI_BRESP), 32'(r), "bresp");
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rdc(input logic [31:0] a, exp, input logic [1:0] r);
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        wt(S_AXI_ARREADY, 20);
        S_AXI_ARVALID <= 1'b0;
        wt(S_AXI_RVALID, 20);
        chk(S_AXI_RDATA, exp, "rdata");
        chk(32'(S_AXI_RRESP), 32'(r), "rresp");
        S_AXI_RREADY <= 1'b0;
    endtask
    // reset values, reserved bits, a read-only word and an unmapped word
    task automatic t_regs();
        for (int i = 0; i < 8; i++)
        begin
            rdc(RESP0_ADDR + 32'(4 * i), 32'h0, AXI_OKAY);
        end
        wr(TMR_ADDR, 32'hffff_ffff, AXI_OKAY);
        rdc(TMR_ADDR, 32'hffff_ffff, AXI_OKAY);
        wr(LEN_ADDR, 32'hffff_ffff, AXI_OKAY);
        rdc(LEN_ADDR, 32'h0000_ffff, AXI_OKAY);
        wr(RESP0_ADDR, 32'h1234_5678, AXI_OKAY);
        rdc(RESP0_ADDR, 32'h0, AXI_OKAY);
        wr(32'he008_c000, 32'h1, AXI_DECERR);
        rdc(32'he008_c000, 32'h0, AXI_DECERR);
    endtask
    // status bits go in msb first; the long form spreads over four words
    task automatic t_resp(input logic [127:0] v, input logic lg);
        @(posedge CLK_SYS);
        RESP_START <= 1'b1;
        LONG_RESPONSE_SELECT <= lg;
        for (int i = 0; i < (lg ? LONG_BITS : SHORT_BITS); i++)
        begin
            @(posedge CLK_SYS);
            RESP_START <= 1'b0;
            RESP_BIT <= v[127 - i];
            RESP_BIT_VALID <= 1'b1;
        end
        @(posedge CLK_SYS);
        RESP_BIT_VALID <= 1'b0;
        RESP_DONE <= 1'b1;
        @(posedge CLK_SYS);
        RESP_DONE <= 1'b0;
        rdc(RESP0_ADDR, v[127:96], AXI_OKAY);
        if (lg)
        begin
            rdc(RESP1_ADDR, v[95:64], AXI_OKAY);
            rdc(RESP2_ADDR, v[63:32], AXI_OKAY);
            rdc(RESP3_ADDR, {v[31:1], 1'b0}, AXI_OKAY);
        end
    endtask
    // every block size code, reserved ones included
    task automatic t_blk();
        for (int e = 0; e < 16; e++)
        begin
            wr(CTRL_ADDR, 32'(e << 4), AXI_OKAY);
            @(posedge CLK_SYS);
            chk(32'(BLOCK_LEN), (e <= BLK_MAX) ? 32'(1 << e) : 32'h0, "blklen");
            rdc(CTRL_ADDR, 32'(e << 4), AXI_OKAY);
        end
    endtask
    // two-byte transfer; the enable bit is never cleared between runs
    task automatic t_xfer(input logic [7:0] c);
        wr(TMR_ADDR, 32'h0000_0100, AXI_OKAY);
        wr(LEN_ADDR, 32'h2, AXI_OKAY);
        wr(CTRL_ADDR, {24'h0, c}, AXI_OKAY);
        chk({30'h0, TX_ACTIVE, RX_ACTIVE}, c[1] ? 32'h1 : 32'h2, "wait");
        chk({29'h0, DATA_DIR, STREAM_MODE, DMA_REQUEST}, {29'h0, c[1], c[2], 1'b0}, "mode");
        wr(CNT_ADDR, 32'h55, AXI_OKAY);
        rdc(CNT_ADDR, 32'h2, AXI_OKAY);
        @(posedge CLK_SYS);
        TX_READY <= ~c[1];
        RX_START_BIT <= c[1];
        @(posedge CLK_SYS);
        TX_READY <= 1'b0;
        RX_START_BIT <= 1'b0;
        BYTE_MOVED <= 1'b1;
        #1 chk(32'(DMA_REQUEST), 32'(c[3]), "dma");
        repeat (2) @(posedge CLK_SYS);
        BYTE_MOVED <= 1'b0;
        wt(DATA_END_FLAG, 10);
        chk({30'h0, TX_ACTIVE, RX_ACTIVE}, 32'h0, "idle");
        rdc(CNT_ADDR, 32'h0, AXI_OKAY);
        rdc(FLAG_ADDR, 32'h100, AXI_OKAY);
        wr(FLAG_CLR_ADDR, 32'h108, AXI_OKAY);
    endtask
    // no data arrives: the timer runs out in receive-wait or busy
    task automatic t_tmo(input logic rx);
        int n;
        wr(TMR_ADDR, 32'h4, AXI_OKAY);
        wr(LEN_ADDR, 32'h4, AXI_OKAY);
        run <= 1'b1;
        busy_req <= ~rx;
        TX_READY <= ~rx;
        wr(CTRL_ADDR, {30'h0, rx, 1'b1}, AXI_OKAY);
        n = 0;
        while (DATA_TIMEOUT_FLAG !== 1'b1 && n < 100)
        begin
            @(posedge CLK_SYS);
            n++;
        end
        chk(32'(n >= 20 && n <= 64), 32'h1, "tmo time");
        // a timer that never fires would leave the data path stuck, so stop here
        if (DATA_TIMEOUT_FLAG !== 1'b1)
        begin
            close_out();
        end
        chk({30'h0, TX_ACTIVE, RX_ACTIVE}, 32'h0, "tmo idle");
        rdc(FLAG_ADDR, 32'h8, AXI_OKAY);
        run <= 1'b0;
        busy_req <= 1'b0;
        TX_READY <= 1'b0;
        wr(FLAG_CLR_ADDR, 32'h108, AXI_OKAY);
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        S_AXI_AWADDR = '0;
        S_AXI_WDATA = '0;
        S_AXI_ARADDR = '0;
        S_AXI_WSTRB = 4'hf;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {RESP_START, RESP_BIT, RESP_BIT_VALID, RESP_DONE, LONG_RESPONSE_SELECT} = '0;
        {TX_READY, RX_START_BIT, BYTE_MOVED, run, busy_req} = '0;
        SYS_RST = 1'b1;
        repeat (8) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        t_regs();
        t_resp(128'ha5c3_1e69_0000_0000_0000_0000_0000_0000, 1'b0);
        t_resp(128'h8123_4567_89ab_cdef_0f1e_2d3c_4b5a_6979, 1'b1);
        t_blk();
        t_xfer(8'h0b);
        t_xfer(8'h05);
        t_tmo(1'b1);
        t_tmo(1'b0);
        close_out();
    end
endmodule
